// ===== fwls_core.sv
`timescale 1ns/10ps
// What this block does
// RULE_01: Write-enable opcode in a complete frame sets the write latch flag.
// RULE_02: Host sets the latch before any program, erase or status write.
// RULE_03: Host frames write enable: select low, opcode on rising clocks, select high.
// RULE_04: Volatile enable leaves the latch alone, only arms the next status write.
// RULE_05: Host sends volatile enable immediately before the status write.
// RULE_06: Write-disable opcode in a complete frame clears the write latch flag.
// RULE_07: Latch clears at reset and when a program, erase or status write completes.
// RULE_08: Opcodes 05h, 35h, 15h read status registers one, two, three.
// RULE_09: Sample on rising clock edges, drive status on falling edges, MSB first.
// RULE_10: Status reads are accepted at any time, busy or not.
// RULE_11: Status byte repeats every eight-bit slot until select rises.
// RULE_12: Page program byte index wraps at 256 within the page.
// RULE_13: Single-lane double-rate reads: 8-clock opcode, address on both edges.
// RULE_14: Double-rate single and dual use six dummy clocks, quad uses eight.
// RULE_15: Quad-command double-rate reads: 2-clock opcode, one clock per address byte.
// RULE_16: Dual transfers: lane one carries odd bits, lane zero even, high pair first.
// RULE_17: Quad transfers: high nibble first, lane n carries bit n+4 then n.
// RULE_18: Quad-command opcode on four lanes over two clocks, high nibble first.
// RULE_19: Quad-command read dummy count follows the parameter byte upper half.
// RULE_20: Wrapped read length follows the parameter byte lower bits.
// RULE_21: Host sends an all-ones upper nibble in identifier mode bytes.
// RULE_22: Security registers sit at 00h high byte, 10h/20h/30h middle byte.
// RULE_23: A volatile status update never raises the busy flag.
// RULE_24: Quad-command dummy count is two clocks after reset.
// RULE_25: A frame ended before a full opcode is dropped, latch unchanged.
module fwls_core
  import fwls_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        clk_sys_in,
  input  wire logic        rst_in,
  input  wire logic        ce_in,
  // Serial pins
  input  wire logic        cs_n_in,
  input  wire logic        sck_in,
  input  wire logic [3:0]  lane_in,
  output logic      [3:0]  lane_out,
  output logic      [3:0]  lane_oe_n_out,
  // Mode and status sources
  input  wire logic        quad_command_mode_in,
  input  wire logic        busy_in,
  input  wire logic [5:0]  sr1_upper_in,
  input  wire logic [7:0]  sr2_in,
  input  wire logic [7:0]  sr3_in,
  input  wire logic        op_done_in,
  input  wire logic        soft_reset_in,
  // Array read port
  output logic             read_req_out,
  output logic      [23:0] read_addr_out,
  input  wire logic [7:0]  read_data_in,
  // Program data port
  output logic             prog_valid_out,
  output logic      [23:0] prog_addr_out,
  output logic      [7:0]  prog_data_out,
  output logic      [1:0]  sec_reg_sel_out,
  // Status write port and flags
  output logic             sr_write_out,
  output logic             sr_write_volatile_out,
  output logic      [1:0]  sr_write_sel_out,
  output logic      [7:0]  sr_write_data_out,
  output logic             write_latch_flag_out,
  output logic      [7:0]  read_parameter_byte_out
);

  typedef struct packed {
    fwls_state_t state;
    logic        cs_prev;
    logic        sck_prev;
    logic [7:0]  opc;
    logic        opc_done;
    logic [23:0] sh;
    logic [5:0]  cnt;
    logic [5:0]  goal;
    logic        dtr;
    logic [1:0]  wid;
    logic [1:0]  dwid;
    logic        write_latch_flag;
    logic        vol_arm;
    logic [7:0]  param;
    logic [23:0] addr;
    logic [7:0]  obyte;
    logic [7:0]  pidx;
    logic        byte_done;
    logic [3:0]  lane_o;
    logic [3:0]  oe_n;
    logic        rd_req;
    logic        pp_valid;
    logic [7:0]  pp_data;
    logic [23:0] pp_addr;
    logic        sr_wr;
    logic        sr_vol;
    logic [1:0]  sr_sel;
    logic [7:0]  sr_data;
    logic [1:0]  sec_sel;
  } fwls_core_t;

  fwls_core_t st_ff;
  fwls_core_t nxt_st;
  logic [5:0] pin_sync;
  logic       cs_s;
  logic       sck_s;
  logic [3:0] lanes_s;

  // All pins cross into the system clock before any logic looks at them
  fwls_pin_sync #(.WIDTH(6), .RESET_VAL(6'h20)) u_pin_sync (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .ce_in      (ce_in),
    .async_in   ({cs_n_in, sck_in, lane_in}),
    .sync_out   (pin_sync)
  );
  assign cs_s    = pin_sync[5];
  assign sck_s   = pin_sync[4];
  assign lanes_s = pin_sync[3:0];

  // Shift one transfer unit in, highest bits first
  function automatic logic [23:0] shift_in(input logic [23:0] sh, input logic [3:0] l,
                                           input logic [1:0] w);
    unique case (w)
      W_SINGLE: shift_in = {sh[22:0], l[0]};
      W_DUAL:   shift_in = {sh[21:0], l[1:0]}; // RULE_16
      default:  shift_in = {sh[19:0], l};      // RULE_17 RULE_18
    endcase
  endfunction : shift_in

  // Pick transfer unit idx of a byte, highest first
  function automatic logic [3:0] get_unit(input logic [7:0] b, input logic [5:0] idx,
                                          input logic [1:0] w);
    logic [7:0] t;
    t = b << (idx[2:0] << w);
    unique case (w)
      W_SINGLE: get_unit = {2'h0, t[7], 1'h0}; // Single output leaves on lane one
      W_DUAL:   get_unit = {2'h0, t[7:6]};
      default:  get_unit = t[7:4];
    endcase
  endfunction : get_unit

  function automatic logic [3:0] oe_of(input logic [1:0] w);
    unique case (w)
      W_SINGLE: oe_of = OE_SINGLE;
      W_DUAL:   oe_of = OE_DUAL;
      default:  oe_of = OE_QUAD;
    endcase
  endfunction : oe_of

  // Next read address; wrapped reads stay inside an aligned window
  function automatic logic [23:0] next_addr(input logic [23:0] a, input logic wrap,
                                            input logic [7:0] p);
    logic [23:0] m;
    m = (WRAP_BASE << p[PARAM_WRAP_LSB +: 2]) - 24'h000001;
    if (wrap) begin
      next_addr = (a & ~m) | ((a + 24'h000001) & m); // RULE_20
    end else begin
      next_addr = a + 24'h000001;
    end
  endfunction : next_addr

  function automatic logic [1:0] sec_decode(input logic [23:0] a);
    sec_decode = 2'h0;
    if (a[23:16] == SEC_HIGH_BYTE) begin
      if (a[15:8] == SEC_MID_1) sec_decode = 2'h1; // RULE_22
      if (a[15:8] == SEC_MID_2) sec_decode = 2'h2;
      if (a[15:8] == SEC_MID_3) sec_decode = 2'h3;
    end
  endfunction : sec_decode

  function automatic logic [5:0] qpi_dummy(input logic [7:0] p);
    qpi_dummy = DUMMY_QPI_BASE + {3'h0, p[PARAM_DUMMY_LSB +: 2], 1'h0}; // RULE_19
  endfunction : qpi_dummy

  // Busy comes only from the engines, so a volatile refresh reads as idle
  logic [7:0] sr1_live;
  assign sr1_live = {sr1_upper_in, st_ff.write_latch_flag, busy_in}; // RULE_23

  function automatic logic [7:0] sr_pick(input logic [7:0] op, input logic [7:0] s1,
                                         input logic [7:0] s2, input logic [7:0] s3);
    sr_pick = (op == OP_READ_SR2) ? s2 : ((op == OP_READ_SR3) ? s3 : s1);
  endfunction : sr_pick

  logic       rise;
  logic       fall;
  logic       cs_rise;
  logic       step;
  logic       wel_set;
  logic       wel_clr;
  logic [23:0] sh_n;
  logic [7:0]  byte_n;

  assign rise    = sck_s & ~st_ff.sck_prev;
  assign fall    = ~sck_s & st_ff.sck_prev;
  assign cs_rise = cs_s & ~st_ff.cs_prev;
  assign step    = st_ff.dtr ? (rise | fall) : rise;
  assign sh_n    = shift_in(st_ff.sh, lanes_s, st_ff.wid);

  // Frame sequencer; latch, volatile-arm and status-write effects are deferred to the select edge
  always_comb begin
    nxt_st          = st_ff;
    nxt_st.cs_prev  = cs_s;
    nxt_st.sck_prev = sck_s;
    nxt_st.rd_req   = 1'h0;
    nxt_st.pp_valid = 1'h0;
    nxt_st.sr_wr    = 1'h0;
    wel_set         = 1'h0;
    wel_clr         = op_done_in | soft_reset_in; // RULE_07
    byte_n          = sh_n[7:0];
    if (cs_s) begin
      // Partial opcodes never reach this point with opc_done set
      if (cs_rise && st_ff.opc_done) begin // RULE_25 RULE_03
        nxt_st.vol_arm = (st_ff.opc == OP_VOL_ENABLE); // RULE_04 RULE_05
        unique case (st_ff.opc)
          OP_WRITE_ENABLE: wel_set = 1'h1; // RULE_01
          OP_WRITE_DIS:    wel_clr = 1'h1; // RULE_06
          OP_WRITE_SR1, OP_WRITE_SR2, OP_WRITE_SR3: begin
            if (st_ff.byte_done && (st_ff.vol_arm || st_ff.write_latch_flag)) begin
              nxt_st.sr_wr  = 1'h1;
              nxt_st.sr_vol = st_ff.vol_arm;
              nxt_st.sr_sel = (st_ff.opc == OP_WRITE_SR1) ? 2'h1 :
                              ((st_ff.opc == OP_WRITE_SR2) ? 2'h2 : 2'h3);
            end
          end
          default: ;
        endcase
      end
      nxt_st.state     = S_OPC;
      nxt_st.cnt       = '0;
      nxt_st.sh        = '0;
      nxt_st.opc_done  = 1'h0;
      nxt_st.byte_done = 1'h0;
      nxt_st.dtr       = 1'h0;
      nxt_st.pidx      = '0;
      nxt_st.wid       = quad_command_mode_in ? W_QUAD : W_SINGLE; // RULE_18
      nxt_st.oe_n      = OE_OFF;
      nxt_st.lane_o    = '0;
    end else begin
      unique case (st_ff.state)
        S_OPC: begin
          if (rise) begin // RULE_09
            nxt_st.sh  = sh_n;
            nxt_st.cnt = st_ff.cnt + 6'h01;
            if (st_ff.cnt + 6'h01 == (quad_command_mode_in ? OPC_UNITS_QPI : OPC_UNITS_SPI)) begin
              nxt_st.opc      = byte_n;
              nxt_st.opc_done = 1'h1;
              nxt_st.cnt      = '0;
              nxt_st.sh       = '0;
              nxt_st.state    = S_SKIP;
              nxt_st.goal     = ADDR_BITS >> st_ff.wid;
              nxt_st.dwid     = st_ff.wid;
              if (quad_command_mode_in) begin
                unique case (byte_n)
                  OP_DTR_WRAP, OP_DTR_FAST, OP_DTR_QUAD: begin // RULE_15
                    nxt_st.state = S_ADDR;
                    nxt_st.dtr   = 1'h1;
                  end
                  OP_PAGE_PROG: nxt_st.state = S_ADDR;
                  default: ;
                endcase
              end else begin
                unique case (byte_n)
                  OP_DTR_FAST, OP_DTR_DUAL, OP_DTR_QUAD: begin // RULE_13
                    nxt_st.state = S_ADDR;
                    nxt_st.dtr   = 1'h1;
                    nxt_st.wid   = (byte_n == OP_DTR_FAST) ? W_SINGLE :
                                   ((byte_n == OP_DTR_DUAL) ? W_DUAL : W_QUAD);
                    nxt_st.dwid  = nxt_st.wid;
                    nxt_st.goal  = ADDR_BITS >> nxt_st.wid;
                  end
                  OP_PAGE_PROG: nxt_st.state = S_ADDR;
                  OP_QUAD_PROG: begin
                    nxt_st.state = S_ADDR;
                    nxt_st.dwid  = W_QUAD;
                  end
                  default: ;
                endcase
              end
              unique case (byte_n)
                OP_READ_SR1, OP_READ_SR2, OP_READ_SR3: nxt_st.state = S_SR; // RULE_08 RULE_10
                OP_WRITE_SR1, OP_WRITE_SR2, OP_WRITE_SR3, OP_SET_PARAM: begin
                  nxt_st.state = S_WIN;
                  nxt_st.goal  = BYTE_BITS >> st_ff.wid;
                end
                default: ;
              endcase
            end
          end
        end
        S_ADDR: begin
          if (step && (rise || st_ff.cnt != 6'h00)) begin // RULE_13 Opcode clock's fall skipped
            nxt_st.sh  = sh_n;
            nxt_st.cnt = st_ff.cnt + 6'h01;
            if (st_ff.cnt + 6'h01 == st_ff.goal) begin
              nxt_st.addr    = sh_n;
              nxt_st.sec_sel = sec_decode(sh_n);
              nxt_st.cnt     = '0;
              nxt_st.wid     = st_ff.dwid;
              if (st_ff.dtr) begin
                nxt_st.state = S_DUMMY;
                nxt_st.goal  = quad_command_mode_in ? qpi_dummy(st_ff.param) :
                               ((st_ff.opc == OP_DTR_QUAD) ? DUMMY_SPI_QUAD : DUMMY_SPI_SD); // RULE_14
              end else begin
                nxt_st.state = S_WIN;
                nxt_st.goal  = BYTE_BITS >> st_ff.dwid;
              end
            end
          end
        end
        S_DUMMY: begin
          if (rise) begin
            nxt_st.cnt = st_ff.cnt + 6'h01;
            if (st_ff.cnt + 6'h01 == st_ff.goal) begin // RULE_14
              nxt_st.state  = S_RD;
              nxt_st.cnt    = '0;
              nxt_st.rd_req = 1'h1;
            end
          end
        end
        S_RD: begin
          // Array byte is taken at the first edge of each slot
          if (rise | fall) begin
            if (st_ff.cnt == 6'h00) begin
              nxt_st.obyte  = read_data_in;
              nxt_st.addr   = next_addr(st_ff.addr, st_ff.opc == OP_DTR_WRAP, st_ff.param);
              nxt_st.rd_req = 1'h1;
              nxt_st.lane_o = get_unit(read_data_in, 6'h00, st_ff.wid); // RULE_17
            end else begin
              nxt_st.lane_o = get_unit(st_ff.obyte, st_ff.cnt, st_ff.wid);
            end
            nxt_st.oe_n = oe_of(st_ff.wid);
            nxt_st.cnt  = (st_ff.cnt + 6'h01 == (BYTE_BITS >> st_ff.wid)) ? 6'h00 :
                          st_ff.cnt + 6'h01;
          end
        end
        S_SR: begin
          // Reloaded each slot so a busy poll sees the engines finish
          if (fall) begin // RULE_09 RULE_11
            if (st_ff.cnt == 6'h00) begin
              nxt_st.obyte  = sr_pick(st_ff.opc, sr1_live, sr2_in, sr3_in);
              nxt_st.lane_o = get_unit(nxt_st.obyte, 6'h00, st_ff.wid);
            end else begin
              nxt_st.lane_o = get_unit(st_ff.obyte, st_ff.cnt, st_ff.wid);
            end
            nxt_st.oe_n = oe_of(st_ff.wid);
            nxt_st.cnt  = (st_ff.cnt + 6'h01 == (BYTE_BITS >> st_ff.wid)) ? 6'h00 :
                          st_ff.cnt + 6'h01;
          end
        end
        S_WIN: begin
          if (rise) begin
            nxt_st.sh  = sh_n;
            nxt_st.cnt = st_ff.cnt + 6'h01;
            if (st_ff.cnt + 6'h01 == st_ff.goal) begin
              nxt_st.cnt = '0;
              if (st_ff.opc == OP_SET_PARAM) begin
                nxt_st.param = byte_n;
              end else if (st_ff.opc == OP_PAGE_PROG || st_ff.opc == OP_QUAD_PROG) begin
                nxt_st.pp_valid = st_ff.write_latch_flag;
                nxt_st.pp_data  = byte_n;
                nxt_st.pp_addr  = {st_ff.addr[23:8], st_ff.addr[7:0] + st_ff.pidx};
                nxt_st.pidx     = st_ff.pidx + 8'h01; // RULE_12
              end else if (!st_ff.byte_done) begin
                nxt_st.sr_data   = byte_n;
                nxt_st.byte_done = 1'h1;
              end
            end
          end
        end
        S_SKIP: ;
        default: nxt_st.state = S_SKIP;
      endcase
    end
    // A set arriving with an automatic clear wins
    if (wel_clr) nxt_st.write_latch_flag = 1'h0;
    if (wel_set) nxt_st.write_latch_flag = 1'h1; // RULE_01
    if (soft_reset_in) begin
      nxt_st.param   = PARAM_RESET; // RULE_24
      nxt_st.vol_arm = 1'h0;
    end
  end

  // Single state register; enable low freezes everything
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      st_ff       <= '0;
      st_ff.state <= S_OPC;
      st_ff.cs_prev <= 1'h1;
      st_ff.oe_n  <= OE_OFF;
      st_ff.param <= PARAM_RESET; // RULE_24
    end else if (ce_in) begin
      st_ff <= nxt_st;
    end
  end

  assign lane_out                = st_ff.lane_o;
  assign lane_oe_n_out           = st_ff.oe_n;
  assign read_req_out            = st_ff.rd_req;
  assign read_addr_out           = st_ff.addr;
  assign prog_valid_out          = st_ff.pp_valid;
  assign prog_addr_out           = st_ff.pp_addr;
  assign prog_data_out           = st_ff.pp_data;
  assign sec_reg_sel_out         = st_ff.sec_sel;
  assign sr_write_out            = st_ff.sr_wr;
  assign sr_write_volatile_out   = st_ff.sr_vol;
  assign sr_write_sel_out        = st_ff.sr_sel;
  assign sr_write_data_out       = st_ff.sr_data;
  assign write_latch_flag_out    = st_ff.write_latch_flag;
  assign read_parameter_byte_out = st_ff.param;

  chk_wel_set: assert property (@(posedge clk_sys_in) disable iff (rst_in) // RULE_01
    ce_in && cs_rise && st_ff.opc_done && st_ff.opc == OP_WRITE_ENABLE |=> st_ff.write_latch_flag)
    else $error("write enable did not set latch");
  chk_wel_disable: assert property (@(posedge clk_sys_in) disable iff (rst_in) // RULE_06
    ce_in && cs_rise && st_ff.opc_done && st_ff.opc == OP_WRITE_DIS |=> !st_ff.write_latch_flag)
    else $error("write disable did not clear latch");
  chk_vol_keeps_wel: assert property (@(posedge clk_sys_in) disable iff (rst_in) // RULE_04
    ce_in && cs_rise && st_ff.opc_done && st_ff.opc == OP_VOL_ENABLE &&
    !op_done_in && !soft_reset_in |=> st_ff.write_latch_flag == $past(st_ff.write_latch_flag) && st_ff.vol_arm)
    else $error("volatile enable disturbed latch");
  chk_auto_clear: assert property (@(posedge clk_sys_in) disable iff (rst_in) // RULE_07
    ce_in && op_done_in && !wel_set |=> !st_ff.write_latch_flag)
    else $error("latch not cleared on completion");
  chk_partial_drop: assert property (@(posedge clk_sys_in) disable iff (rst_in) // RULE_25
    ce_in && cs_rise && !st_ff.opc_done && !op_done_in && !soft_reset_in
    |=> $stable(st_ff.write_latch_flag) && !st_ff.sr_wr)
    else $error("partial opcode had an effect");
  chk_status_msb: assert property (@(posedge clk_sys_in) disable iff (rst_in) // RULE_09
    ce_in && !cs_s && st_ff.state == S_SR && fall && st_ff.cnt == 6'h01 && st_ff.wid == W_SINGLE
    |=> lane_out[1] == $past(st_ff.obyte[6]) && lane_oe_n_out == OE_SINGLE)
    else $error("status bit order wrong");
  chk_dummy_count: assert property (@(posedge clk_sys_in) disable iff (rst_in) // RULE_14
    ce_in && !cs_s && st_ff.state == S_DUMMY && rise && st_ff.cnt + 6'h01 == st_ff.goal
    |=> st_ff.state == S_RD && read_req_out)
    else $error("dummy phase end wrong");
  chk_param_default: assert property (@(posedge clk_sys_in) disable iff (rst_in) // RULE_24
    ce_in && soft_reset_in |=> qpi_dummy(st_ff.param) == DUMMY_QPI_BASE)
    else $error("dummy default not two clocks");
  chk_prog_wrap: assert property (@(posedge clk_sys_in) disable iff (rst_in) // RULE_12
    prog_valid_out |-> prog_addr_out[23:8] == st_ff.addr[23:8])
    else $error("program address left its page");
  chk_idle_release: assert property (@(posedge clk_sys_in) disable iff (rst_in) // RULE_11
    ce_in && cs_s |=> lane_oe_n_out == OE_OFF && st_ff.state == S_OPC)
    else $error("lanes driven while deselected");

endmodule : fwls_core

// ===== fwls_host.sv
`timescale 1ns/10ps
module fwls_host (
  // Clock
  input  wire logic       clk_sys_in,
  // Pins
  input  wire logic [3:0] lane_in,
  output logic            cs_n_out,
  output logic            sck_out,
  output logic [3:0]      lane_out
);
  // Serial clock stands low between frames
  initial begin
    cs_n_out = 1'b1;
    sck_out  = 1'b0;
    lane_out = 4'hA;
  end
  // Half of the 160 ns link period
  task automatic half();
    repeat (4) @(posedge clk_sys_in);
  endtask : half
  // MSB first on lane zero; unused lanes carry the inverse so nothing stale looks valid
  task automatic frame(input logic [63:0] op, input int nb, input int nrd,
                       output logic [15:0] rd);
    cs_n_out <= 1'b0;
    for (int i = 0; i < nb + 8 * nrd; i++) begin
      lane_out <= {{3{~op[63]}}, op[63]};
      op = op << 1;
      half();
      sck_out <= 1'b1;
      half();
      rd = {rd[14:0], lane_in[1]}; // Sampled just before the fall
      sck_out <= 1'b0;
    end
    half();
    cs_n_out <= 1'b1;
    repeat (3) half();
  endtask : frame
endmodule : fwls_host

// ===== fwls_pin_sync.sv
`timescale 1ns/10ps
module fwls_pin_sync #(
  parameter int              WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // Clock, reset, enable
  input  wire logic             clk_sys_in,
  input  wire logic             rst_in,
  input  wire logic             ce_in,
  // Pin side and synchronised side
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } fwls_sync_t;

  fwls_sync_t st_ff;
  fwls_sync_t nxt_st;

  // Two stages; only the second stage reads the first
  always_comb begin
    nxt_st      = st_ff;
    nxt_st.meta = async_in;
    nxt_st.sync = st_ff.meta;
  end

  // Enable freezes the chain with the rest of the block
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      st_ff <= {RESET_VAL, RESET_VAL};
    end else if (ce_in) begin
      st_ff <= nxt_st;
    end
  end

  assign sync_out = st_ff.sync;

endmodule : fwls_pin_sync

// ===== fwls_pkg.sv
package fwls_pkg;

  // Instruction codes handled by the front-end
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_VOL_ENABLE   = 8'h50;
  localparam logic [7:0] OP_WRITE_DIS    = 8'h04;
  localparam logic [7:0] OP_READ_SR1     = 8'h05;
  localparam logic [7:0] OP_READ_SR2     = 8'h35;
  localparam logic [7:0] OP_READ_SR3     = 8'h15;
  localparam logic [7:0] OP_WRITE_SR1    = 8'h01;
  localparam logic [7:0] OP_WRITE_SR2    = 8'h31;
  localparam logic [7:0] OP_WRITE_SR3    = 8'h11;
  localparam logic [7:0] OP_DTR_FAST     = 8'h0D;
  localparam logic [7:0] OP_DTR_DUAL     = 8'hBD;
  localparam logic [7:0] OP_DTR_QUAD     = 8'hED;
  localparam logic [7:0] OP_DTR_WRAP     = 8'h0E;
  localparam logic [7:0] OP_PAGE_PROG    = 8'h02;
  localparam logic [7:0] OP_QUAD_PROG    = 8'h32;
  localparam logic [7:0] OP_SET_PARAM    = 8'hC0;

  // Lane width codes: bits per transfer unit is 1 << code
  localparam logic [1:0] W_SINGLE = 2'h0;
  localparam logic [1:0] W_DUAL   = 2'h1;
  localparam logic [1:0] W_QUAD   = 2'h2;

  // Phase lengths in bits and clocks
  localparam logic [5:0] ADDR_BITS       = 6'h18;
  localparam logic [5:0] BYTE_BITS       = 6'h08;
  localparam logic [5:0] OPC_UNITS_SPI   = 6'h08;
  localparam logic [5:0] OPC_UNITS_QPI   = 6'h02;
  localparam logic [5:0] DUMMY_SPI_SD    = 6'h06;
  localparam logic [5:0] DUMMY_SPI_QUAD  = 6'h08;
  localparam logic [5:0] DUMMY_QPI_BASE  = 6'h02;
  localparam int         PARAM_DUMMY_LSB = 4;
  localparam int         PARAM_WRAP_LSB  = 0;
  localparam logic [23:0] WRAP_BASE      = 24'h000008;

  // Reset values
  localparam logic [7:0] PARAM_RESET = 8'h00;

  // Security register address fields
  localparam logic [7:0] SEC_HIGH_BYTE = 8'h00;
  localparam logic [7:0] SEC_MID_1     = 8'h10;
  localparam logic [7:0] SEC_MID_2     = 8'h20;
  localparam logic [7:0] SEC_MID_3     = 8'h30;

  // Output enables, low while driving
  localparam logic [3:0] OE_OFF    = 4'hF;
  localparam logic [3:0] OE_SINGLE = 4'hD;
  localparam logic [3:0] OE_DUAL   = 4'hC;
  localparam logic [3:0] OE_QUAD   = 4'h0;

  // Frame phases
  typedef enum logic [2:0] {
    S_OPC   = 3'h0,
    S_ADDR  = 3'h1,
    S_DUMMY = 3'h2,
    S_RD    = 3'h3,
    S_SR    = 3'h4,
    S_WIN   = 3'h5,
    S_SKIP  = 3'h6
  } fwls_state_t;

endpackage : fwls_pkg

// ===== tb.sv
`timescale 1ns/10ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin err_count++; \
  $display("ERROR %0t mismatch got %h exp %h", $time, a, b); end end
module tb
  import fwls_pkg::*;
;
  logic        clk_sys_in = 1'b0;
  logic        rst_in     = 1'b1;
  logic        cs_n, sck, latch;
  logic        busy = 1'b0, op_done = 1'b0, soft_rst = 1'b0;
  logic [3:0]  host_lane, lane_out, oe_n;
  logic [5:0]  sr1u = 6'h00;
  logic [7:0]  sr2 = 8'h00, sr3 = 8'h00;
  logic [15:0] rd;
  logic        sr_wr, sr_vol, pv;
  logic [1:0]  sr_sel, sec;
  logic [7:0]  sr_dat, pdat;
  logic [23:0] paddr;
  int          n_sr = 0, n_pv = 0;
  int          err_count = 0, comparisons = 0, cycles = 0, m_latch = 0;
  int          seed = 32'h0ae4;
  // Pin level: the device wins where its enable is low
  wire  [3:0]  lane_in = (~oe_n & lane_out) | (oe_n & host_lane);
  always #10 clk_sys_in = ~clk_sys_in;
  fwls_host u_fwls_host (.clk_sys_in(clk_sys_in), .lane_in(lane_in), .cs_n_out(cs_n),
    .sck_out(sck), .lane_out(host_lane));
  fwls_core u_fwls_core (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .ce_in(1'b1),
    .cs_n_in(cs_n), .sck_in(sck), .lane_in(lane_in), .lane_out(lane_out),
    .lane_oe_n_out(oe_n), .quad_command_mode_in(1'b0), .busy_in(busy),
    .sr1_upper_in(sr1u), .sr2_in(sr2), .sr3_in(sr3), .op_done_in(op_done),
    .soft_reset_in(soft_rst), .read_req_out(), .read_addr_out(), .read_data_in(8'h00),
    .prog_valid_out(pv), .prog_addr_out(paddr), .prog_data_out(pdat), .sec_reg_sel_out(sec),
    .sr_write_out(sr_wr), .sr_write_volatile_out(sr_vol), .sr_write_sel_out(sr_sel),
    .sr_write_data_out(sr_dat), .write_latch_flag_out(latch), .read_parameter_byte_out());
  // One frame of nb opcode bits; only a whole opcode may move the latch
  task automatic cmd(input logic [7:0] op, input int nb);
    u_fwls_host.frame({op, 56'h0}, nb, 0, rd);
    if (nb == 8 && op == OP_WRITE_ENABLE) m_latch = 1;
    if (nb == 8 && op == OP_WRITE_DIS) m_latch = 0;
    `CHK(latch, m_latch[0])
  endtask : cmd
  // Status read of two slots with random live values
  task automatic rd_sr(input logic [7:0] op);
    logic [31:0] r;
    logic [7:0]  e;
    r = $random(seed);
    @(posedge clk_sys_in);
    busy <= r[0];
    sr1u <= r[6:1];
    sr2  <= r[15:8];
    sr3  <= r[23:16];
    @(posedge clk_sys_in);
    e = (op == OP_READ_SR1) ? {sr1u, m_latch[0], busy} : (op == OP_READ_SR2) ? sr2 : sr3;
    u_fwls_host.frame({op, 56'h0}, 8, 2, rd);
    `CHK(rd[15:8], e)
    `CHK(rd[7:0], e)
  endtask : rd_sr
  // Completion pulse or reset instruction
  task automatic clr(input logic sel);
    @(posedge clk_sys_in);
    op_done  <= ~sel;
    soft_rst <= sel;
    @(posedge clk_sys_in);
    op_done  <= 1'b0;
    soft_rst <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    m_latch = 0;
    `CHK(latch, m_latch[0])
  endtask : clr
  // Status write after 50h, 06h or 04h; only the first two may give a pulse
  task automatic wr_sr(input logic [7:0] pre, input logic [7:0] op);
    int         n;
    logic [7:0] d;
    d = 8'($random(seed));
    cmd(pre, 8);
    n = n_sr;
    u_fwls_host.frame({op, d, 48'h0}, 16, 0, rd);
    `CHK(n_sr - n, int'(pre != OP_WRITE_DIS))
    if (pre != OP_WRITE_DIS) begin
      `CHK(sr_vol, pre == OP_VOL_ENABLE)
      `CHK(sr_sel, (op == OP_WRITE_SR1) ? 2'h1 : (op == OP_WRITE_SR2) ? 2'h2 : 2'h3)
      `CHK(sr_dat, d)
    end
  endtask : wr_sr
  // Two bytes from the last page slot: the second wraps to the page start
  task automatic prog(input logic [7:0] pre);
    int         n;
    logic [7:0] d;
    d = 8'($random(seed));
    cmd(pre, 8);
    n = n_pv;
    u_fwls_host.frame({OP_PAGE_PROG, SEC_HIGH_BYTE, SEC_MID_2, 8'hFF, d, d + 8'h01, 16'h0},
      48, 0, rd);
    `CHK(n_pv - n, (pre == OP_WRITE_ENABLE) ? 2 : 0)
    `CHK(sec, 2'h2)
    if (pre == OP_WRITE_ENABLE) begin
      `CHK(paddr, {SEC_HIGH_BYTE, SEC_MID_2, 8'h00})
      `CHK(pdat, d + 8'h01)
    end
  endtask : prog
  task automatic end_sim();
    $display("counts: %0d comparisons, %0d mismatches", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_sim
  // Run needs about 2900 cycles, so this ceiling only trips on a hang
  always @(posedge clk_sys_in) begin
    cycles <= cycles + 1;
    if (sr_wr) n_sr++;
    if (pv) n_pv++;
    if (cycles == 20000) begin
      err_count++;
      end_sim();
    end
  end
  // Main sequence
  initial begin
    repeat (3) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    repeat (3) @(posedge clk_sys_in);
    cmd(OP_WRITE_ENABLE, 8);
    rd_sr(OP_READ_SR1);
    rd_sr(OP_READ_SR2);
    rd_sr(OP_READ_SR3);
    $display("test status reads done");
    cmd(OP_VOL_ENABLE, 8);
    cmd(OP_WRITE_DIS, 8);
    cmd(OP_WRITE_ENABLE, 4);
    rd_sr(OP_READ_SR1);
    $display("test latch codes done");
    wr_sr(OP_VOL_ENABLE, OP_WRITE_SR2);
    wr_sr(OP_WRITE_ENABLE, OP_WRITE_SR3);
    wr_sr(OP_WRITE_DIS, OP_WRITE_SR1);
    prog(OP_WRITE_ENABLE);
    prog(OP_WRITE_DIS);
    $display("test writes done");
    cmd(OP_WRITE_ENABLE, 8);
    clr(1'b0);
    cmd(OP_WRITE_ENABLE, 8);
    clr(1'b1);
    $display("test latch clears done");
    end_sim();
  end
endmodule : tb
